// >>> core/tfcc_top.sv
// tfcc_top: transmit control and hardware configuration registers with
// the small stop sequencer that ties them to the transmit engine.
// assumes: wishbone master keeps the request steady until ack; the
// transmit engine reports halted between frames and when disabled.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps

// What this block does
// - status flush clears status pointers, self-clears
// - data flush clears data pointers, self-clears
// - full status fifo suspends unless overrun allowed
// - overrun allow never gates full interrupt
// - enable bit lets transmitter send queued data
// - enable clears itself after stop completes
// - stop finishes current frame, then self-clears
// - stop bit writes ignored while it reads one
// - fifo size field in kilobytes, max fourteen
// - status fifo takes 512 bytes, data rest
// - data fifo holds frame data and commands
// - receive side gets 16KB minus transmit allocation
// - clock select chooses internal or external clocks
// - 00/11 internal, 01 external, 10 disabled
module tfcc_top (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// wishbone slave
	input tfcc_pkg::tfcc_wb_req_type wb_req_i,
	output tfcc_pkg::tfcc_wb_rsp_type wb_rsp_o,
	// transmit engine
	input tfcc_pkg::tfcc_txe_stat_type txe_stat_i,
	output tfcc_pkg::tfcc_txe_ctrl_type txe_ctrl_o,
	// configuration
	output logic must_write_one_o,
	output logic [3:0] tx_fifo_size_o,
	output logic [14:0] tx_sts_bytes_o,
	output logic [14:0] tx_dat_bytes_o,
	output logic [14:0] rx_bytes_o,
	// mii clock steering
	output logic mii_clk_internal_o,
	output logic mii_clk_external_o,
	output logic mii_clk_disabled_o
);
	import tfcc_pkg::*;

	typedef struct packed {
		tfcc_tx_state_type st;
		logic ack;
		logic [31:0] rdata;
		logic stop;
		logic tx_on;
		logic sao;
		logic must_one;
		logic [3:0] fifo_sz;
		logic [1:0] clk_sel;
		logic sts_clr;
		logic dat_clr;
		logic run;
		logic sts_full_irq;
		logic stop_req;
	} tfcc_regs_type;

	tfcc_regs_type regs_r;
	tfcc_regs_type regs_nxt;

	// bus decode
	logic req_live;
	logic hit_tx;
	logic hit_hw;
	logic wr_go;
	logic [31:0] tx_view;
	logic [31:0] hw_view;
	logic [31:0] wmask;
	logic [31:0] wdat;

	// engine view
	logic stop_done;
	logic suspend;

	assign req_live = wb_req_i.cyc && wb_req_i.stb;
	assign hit_tx = (wb_req_i.adr[7:2] == TFCC_TX_CTRL_OFS[7:2]);
	assign hit_hw = (wb_req_i.adr[7:2] == TFCC_HARDWARE_CONFIGURATION_OFS[7:2]);

	// a write lands on the edge where the master sees ack
	assign wr_go = req_live && wb_req_i.we && regs_r.ack;

	// expand byte selects into a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wb_req_i.sel[i]}};
		end
	end

	assign wdat = wb_req_i.dat & wmask;

	// read views; everything not listed is zero
	always_comb begin
		tx_view = 32'h0000_0000;
		tx_view[TFCC_STS_FLUSH_BIT] = regs_r.sts_clr;
		tx_view[TFCC_DAT_FLUSH_BIT] = regs_r.dat_clr;
		tx_view[TFCC_SAO_BIT] = regs_r.sao;
		tx_view[TFCC_TX_ON_BIT] = regs_r.tx_on;
		tx_view[TFCC_STOP_BIT] = regs_r.stop;
	end

	always_comb begin
		hw_view = 32'h0000_0000;
		hw_view[TFCC_MUST_ONE_BIT] = regs_r.must_one;
		hw_view[TFCC_FIFO_SZ_LSB +: 4] = regs_r.fifo_sz;
		hw_view[TFCC_CLK_SEL_LSB +: 2] = regs_r.clk_sel;
	end

	// engine has parked after a stop request
	assign stop_done = regs_r.stop && txe_stat_i.halted;

	// full status fifo holds the engine off unless overrun is allowed
	assign suspend = txe_stat_i.sts_full && !regs_r.sao;

	always_comb begin
		regs_nxt = regs_r;

		// single cycle strobes drop unless written again
		regs_nxt.sts_clr = 1'b0;
		regs_nxt.dat_clr = 1'b0;

		// bus answer: ack one cycle, then drop
		regs_nxt.ack = req_live && !regs_r.ack;
		regs_nxt.rdata = 32'h0000_0000;
		if (req_live && !regs_r.ack && !wb_req_i.we) begin
			if (hit_tx) begin
				regs_nxt.rdata = tx_view;
			end else if (hit_hw) begin
				regs_nxt.rdata = hw_view;
			end
		end

		// hardware completion of a stop comes first, so that a software
		// write in the same cycle still has the final say on tx_on
		if (stop_done) begin
			regs_nxt.stop = 1'b0;
			regs_nxt.tx_on = 1'b0;
		end

		if (wr_go && hit_tx) begin
			if (wmask[TFCC_STS_FLUSH_BIT]) begin
				regs_nxt.sts_clr = wdat[TFCC_STS_FLUSH_BIT];
			end
			if (wmask[TFCC_DAT_FLUSH_BIT]) begin
				regs_nxt.dat_clr = wdat[TFCC_DAT_FLUSH_BIT];
			end
			if (wmask[TFCC_SAO_BIT]) begin
				regs_nxt.sao = wdat[TFCC_SAO_BIT];
			end
			if (wmask[TFCC_TX_ON_BIT]) begin
				regs_nxt.tx_on = wdat[TFCC_TX_ON_BIT];
			end
			// a pending stop cannot be cancelled or re-armed by software
			if (wmask[TFCC_STOP_BIT] && !regs_r.stop) begin
				regs_nxt.stop = wdat[TFCC_STOP_BIT];
			end
		end

		// no interlock against live engines here; software owns that
		if (wr_go && hit_hw) begin
			if (wmask[TFCC_MUST_ONE_BIT]) begin
				regs_nxt.must_one = wdat[TFCC_MUST_ONE_BIT];
			end
			if (wmask[TFCC_FIFO_SZ_LSB]) begin
				regs_nxt.fifo_sz = wdat[TFCC_FIFO_SZ_LSB +: 4];
			end
			if (wmask[TFCC_CLK_SEL_LSB]) begin
				regs_nxt.clk_sel = wdat[TFCC_CLK_SEL_LSB +: 2];
			end
		end

		// sequencer mirrors the control bits for the engine
		case (regs_r.st)
			TFCC_ST_OFF: begin
				if (regs_nxt.tx_on && !regs_nxt.stop) begin
					regs_nxt.st = TFCC_ST_ON;
				end else if (regs_nxt.stop) begin
					regs_nxt.st = TFCC_ST_STOPPING;
				end
			end
			TFCC_ST_ON: begin
				if (regs_nxt.stop) begin
					regs_nxt.st = TFCC_ST_STOPPING;
				end else if (!regs_nxt.tx_on) begin
					regs_nxt.st = TFCC_ST_OFF;
				end
			end
			TFCC_ST_STOPPING: begin
				if (!regs_nxt.stop) begin
					regs_nxt.st = regs_nxt.tx_on ? TFCC_ST_ON : TFCC_ST_OFF;
				end
			end
			default: begin
				regs_nxt.st = TFCC_ST_OFF;
			end
		endcase

		// engine may start frames only while on and not suspended;
		// during a stop it may only finish the frame already begun
		regs_nxt.run = regs_nxt.tx_on && !suspend;

		// full flag raised whatever the overrun setting
		regs_nxt.sts_full_irq = txe_stat_i.sts_full;

		// stop request to the engine leaves a flop, not a state decode
		regs_nxt.stop_req = (regs_nxt.st == TFCC_ST_STOPPING);
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			regs_r.st <= TFCC_ST_OFF;
			regs_r.ack <= 1'b0;
			regs_r.rdata <= 32'h0000_0000;
			regs_r.stop <= 1'b0;
			regs_r.tx_on <= 1'b0;
			regs_r.sao <= 1'b0;
			regs_r.must_one <= TFCC_MUST_ONE_RST;
			regs_r.fifo_sz <= TFCC_FIFO_SZ_RST;
			regs_r.clk_sel <= TFCC_CLK_SEL_RST;
			regs_r.sts_clr <= 1'b0;
			regs_r.dat_clr <= 1'b0;
			regs_r.run <= 1'b0;
			regs_r.sts_full_irq <= 1'b0;
			regs_r.stop_req <= 1'b0;
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// bus outputs
	assign wb_rsp_o.ack = regs_r.ack;
	assign wb_rsp_o.dat = regs_r.rdata;

	// engine outputs
	assign txe_ctrl_o.enable = regs_r.tx_on;
	assign txe_ctrl_o.run = regs_r.run;
	assign txe_ctrl_o.stop_req = regs_r.stop_req;
	assign txe_ctrl_o.sts_ptr_clr = regs_r.sts_clr;
	assign txe_ctrl_o.dat_ptr_clr = regs_r.dat_clr;
	assign txe_ctrl_o.sts_full_irq = regs_r.sts_full_irq;

	// configuration outputs
	assign must_write_one_o = regs_r.must_one;
	assign tx_fifo_size_o = regs_r.fifo_sz;

	tfcc_fifo_alloc u_alloc (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.fifo_sz_i(regs_r.fifo_sz),
		.tx_sts_bytes_o(tx_sts_bytes_o),
		.tx_dat_bytes_o(tx_dat_bytes_o),
		.rx_bytes_o(rx_bytes_o)
	);

	tfcc_clk_sel u_clk_sel (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.sel_i(regs_r.clk_sel),
		.internal_o(mii_clk_internal_o),
		.external_o(mii_clk_external_o),
		.disabled_o(mii_clk_disabled_o)
	);

endmodule : tfcc_top

// >>> core/tfcc_pkg.sv
// tfcc_pkg: constants and carrier types for the transmit control and
// hardware configuration register bank.
// assumes: classic wishbone slave, 8-bit byte address, 32-bit data.
package tfcc_pkg;

	// register byte addresses
	localparam logic [7:0] TFCC_TX_CTRL_OFS = 8'h70;
	localparam logic [7:0] TFCC_HARDWARE_CONFIGURATION_OFS = 8'h74;

	// transmit_control field positions
	localparam int TFCC_STOP_BIT = 0;
	localparam int TFCC_TX_ON_BIT = 1;
	localparam int TFCC_SAO_BIT = 2;
	localparam int TFCC_DAT_FLUSH_BIT = 14;
	localparam int TFCC_STS_FLUSH_BIT = 15;

	// hardware_configuration field positions
	localparam int TFCC_CLK_SEL_LSB = 5;
	localparam int TFCC_FIFO_SZ_LSB = 16;
	localparam int TFCC_MUST_ONE_BIT = 20;

	// reset values
	localparam logic [3:0] TFCC_FIFO_SZ_RST = 4'h5;
	localparam logic [1:0] TFCC_CLK_SEL_RST = 2'h0;
	localparam logic TFCC_MUST_ONE_RST = 1'b0;

	// fifo memory split, in bytes
	localparam logic [14:0] TFCC_MEM_BYTES = 15'h4000;
	localparam logic [14:0] TFCC_STS_BYTES = 15'h0200;
	localparam logic [3:0] TFCC_FIFO_SZ_MAX = 4'hE;
	localparam int TFCC_KB_SHIFT = 10;

	// mii clock source codes
	localparam logic [1:0] TFCC_CLK_INT_A = 2'h0;
	localparam logic [1:0] TFCC_CLK_EXT = 2'h1;
	localparam logic [1:0] TFCC_CLK_OFF = 2'h2;
	localparam logic [1:0] TFCC_CLK_INT_B = 2'h3;

	typedef enum logic [1:0] {
		TFCC_ST_OFF = 2'b00,
		TFCC_ST_ON = 2'b01,
		TFCC_ST_STOPPING = 2'b10
	} tfcc_tx_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tfcc_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} tfcc_wb_rsp_type;

	// from the transmit engine
	typedef struct packed {
		logic halted;
		logic sts_full;
	} tfcc_txe_stat_type;

	// to the transmit engine and fifo controllers
	typedef struct packed {
		logic enable;
		logic run;
		logic stop_req;
		logic sts_ptr_clr;
		logic dat_ptr_clr;
		logic sts_full_irq;
	} tfcc_txe_ctrl_type;

endpackage : tfcc_pkg

// >>> core/tfcc_fifo_alloc.sv
// tfcc_fifo_alloc: turns the transmit fifo size field into byte limits.
// assumes: size field is steady while both engines are stopped.
`timescale 1ns/1ps
module tfcc_fifo_alloc (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// configuration
	input wire logic [3:0] fifo_sz_i,
	// byte budgets
	output logic [14:0] tx_sts_bytes_o,
	output logic [14:0] tx_dat_bytes_o,
	output logic [14:0] rx_bytes_o
);
	import tfcc_pkg::*;

	logic [3:0] units;
	logic [14:0] tx_total;

	// field above the maximum is held at the maximum
	assign units = (fifo_sz_i > TFCC_FIFO_SZ_MAX) ? TFCC_FIFO_SZ_MAX : fifo_sz_i;
	assign tx_total = 15'({units, 10'h000});

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_sts_bytes_o <= 15'h0000;
			tx_dat_bytes_o <= 15'h0000;
			rx_bytes_o <= 15'h0000;
		end else begin
			tx_sts_bytes_o <= TFCC_STS_BYTES;
			// data and command words share this budget
			tx_dat_bytes_o <= tx_total - TFCC_STS_BYTES;
			rx_bytes_o <= TFCC_MEM_BYTES - tx_total;
		end
	end

endmodule : tfcc_fifo_alloc

// >>> core/tfcc_clk_sel.sv
// tfcc_clk_sel: decodes the mii clock source field into steering enables.
// assumes: downstream clock muxing is glitch safe on its own.
`timescale 1ns/1ps
module tfcc_clk_sel (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// configuration
	input wire logic [1:0] sel_i,
	// steering
	output logic internal_o,
	output logic external_o,
	output logic disabled_o
);
	import tfcc_pkg::*;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			internal_o <= 1'b1;
			external_o <= 1'b0;
			disabled_o <= 1'b0;
		end else begin
			internal_o <= (sel_i == TFCC_CLK_INT_A) || (sel_i == TFCC_CLK_INT_B);
			external_o <= (sel_i == TFCC_CLK_EXT);
			disabled_o <= (sel_i == TFCC_CLK_OFF);
		end
	end

endmodule : tfcc_clk_sel

// >>> verif/tfcc_top_chk.sv
// tfcc_top_chk: port level assertions for the register bank.
// assumes: bound to tfcc_top, one clock, async high reset.
`timescale 1ns/1ps
module tfcc_top_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// watched ports
	input tfcc_pkg::tfcc_wb_req_type wb_req_i,
	input tfcc_pkg::tfcc_wb_rsp_type wb_rsp_o,
	input tfcc_pkg::tfcc_txe_stat_type txe_stat_i,
	input tfcc_pkg::tfcc_txe_ctrl_type txe_ctrl_o,
	input logic [14:0] tx_sts_bytes_o,
	input logic [14:0] tx_dat_bytes_o,
	input logic [14:0] rx_bytes_o,
	input logic mii_clk_internal_o,
	input logic mii_clk_external_o,
	input logic mii_clk_disabled_o
);
	import tfcc_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic wr_tc;
	logic [15:0] sum;
	// write to transmit_control committing at this edge
	assign wr_tc = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_rsp_o.ack
		&& wb_req_i.adr == TFCC_TX_CTRL_OFS;
	assign sum = {1'b0, tx_sts_bytes_o} + tx_dat_bytes_o + rx_bytes_o;
	chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("request not acknowledged next cycle");
	chk_sts_flush: assert property (wr_tc && wb_req_i.sel[1] && wb_req_i.dat[15]
		|=> txe_ctrl_o.sts_ptr_clr ##1 !txe_ctrl_o.sts_ptr_clr) else $error("status flush pulse");
	chk_dat_flush: assert property (wr_tc && wb_req_i.sel[1] && wb_req_i.dat[14]
		|=> txe_ctrl_o.dat_ptr_clr ##1 !txe_ctrl_o.dat_ptr_clr) else $error("data flush pulse");
	chk_irq_follow: assert property (txe_ctrl_o.sts_full_irq == $past(txe_stat_i.sts_full))
		else $error("full interrupt not tracking status full");
	chk_run_gate: assert property (txe_ctrl_o.run |-> txe_ctrl_o.enable)
		else $error("run without enable");
	chk_stop_hold: assert property (txe_ctrl_o.stop_req && !txe_stat_i.halted
		|=> txe_ctrl_o.stop_req) else $error("stop dropped before halt");
	chk_stop_done: assert property (txe_ctrl_o.stop_req && txe_stat_i.halted
		|-> ##[1:2] !txe_ctrl_o.stop_req && !txe_ctrl_o.enable) else $error("stop not completed");
	chk_alloc_sum: assert property (!$past(sys_rst_i) |-> sum == 16'h4000
		&& tx_sts_bytes_o == TFCC_STS_BYTES) else $error("memory split wrong");
	chk_alloc_cap: assert property (tx_dat_bytes_o <= 15'h3600)
		else $error("data budget above cap");
	chk_clk_onehot: assert property ($onehot({mii_clk_internal_o, mii_clk_external_o,
		mii_clk_disabled_o})) else $error("clock steering not one hot");
	cov_stop: cover property (txe_ctrl_o.stop_req && txe_stat_i.halted);
	cov_flush: cover property (txe_ctrl_o.sts_ptr_clr);
	cov_suspend: cover property (txe_stat_i.sts_full && txe_ctrl_o.enable && !txe_ctrl_o.run);
endmodule : tfcc_top_chk
bind tfcc_top tfcc_top_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .txe_stat_i(txe_stat_i),
	.txe_ctrl_o(txe_ctrl_o), .tx_sts_bytes_o(tx_sts_bytes_o),
	.tx_dat_bytes_o(tx_dat_bytes_o), .rx_bytes_o(rx_bytes_o),
	.mii_clk_internal_o(mii_clk_internal_o), .mii_clk_external_o(mii_clk_external_o),
	.mii_clk_disabled_o(mii_clk_disabled_o));

// >>> verif/tb_tfcc_top.sv
// tb_tfcc_top: directed bench for the register bank.
// assumes: classic wishbone, engine status driven by the bench.
`timescale 1ns/1ps
module tb_tfcc_top;
	import tfcc_pkg::*;
	logic core_clk_i, sys_rst_i, mw1, mi, me, md;
	tfcc_wb_req_type req;
	tfcc_wb_rsp_type rsp;
	tfcc_txe_stat_type st;
	tfcc_txe_ctrl_type ctl;
	logic [3:0] sz;
	logic [14:0] sb, db, rb;
	logic [31:0] rd;
	int error_cnt, tests_run, n;
	tfcc_top u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_req_i(req),
		.wb_rsp_o(rsp), .txe_stat_i(st), .txe_ctrl_o(ctl), .must_write_one_o(mw1),
		.tx_fifo_size_o(sz), .tx_sts_bytes_o(sb), .tx_dat_bytes_o(db), .rx_bytes_o(rb),
		.mii_clk_internal_o(mi), .mii_clk_external_o(me), .mii_clk_disabled_o(md));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// holds the request until ack is sampled, then releases
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
		do @(posedge core_clk_i); while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req <= '0;
	endtask : wb
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask : tick
	task automatic t_reset;
		tick(2);
		chk({sz, mw1, mi, me, md}, {4'h5, 1'b0, 3'b100});
		chk({sb, db, rb}, {15'h0200, 15'h1200, 15'h2C00});
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h0);
		wb(0, 8'h74, 4'hF, 0, rd);
		chk(rd, 32'h0005_0000);
		$display("reset test done");
	endtask : t_reset
	task automatic t_rsvd;
		wb(1, 8'h74, 4'hF, 32'hFFFF_FFFF, rd);
		wb(0, 8'h74, 4'hF, 0, rd);
		chk(rd, 32'h001F_0060);
		wb(1, 8'h70, 4'hF, 32'hFFFF_3FF8, rd);
		wb(1, 8'h78, 4'hF, 32'hFFFF_FFFF, rd);
		wb(0, 8'h78, 4'hF, 0, rd);
		chk(rd, 32'h0);
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h0);
		$display("reserved test done");
	endtask : t_rsvd
	// sizes below 2 are a software error, so the sweep starts at 2
	task automatic t_alloc;
		for (int s = 2; s < 16; s++) begin
			// transmitter is still off here, so configuration writes are legal
			wb(1, 8'h74, 4'hF, {11'h0, 1'b1, 4'(s), 9'h0, 2'(s), 5'h0}, rd);
			tick(2);
			n = (s > 14) ? 14 : s;
			chk({mw1, sz}, {1'b1, 4'(s)});
			chk({db, rb}, {15'(n * 1024 - 512), 15'(16384 - n * 1024)});
			chk({mi, me, md}, (s % 4 == 1) ? 3'b010 : (s % 4 == 2) ? 3'b001 : 3'b100);
		end
		$display("allocation test done");
	endtask : t_alloc
	task automatic t_run;
		wb(1, 8'h70, 4'h1, 32'h2, rd);
		tick(2);
		chk({ctl.enable, ctl.run}, 2'b11);
		@(posedge core_clk_i);
		st.sts_full <= 1'b1;
		tick(2);
		chk({ctl.run, ctl.sts_full_irq}, 2'b01);
		wb(1, 8'h70, 4'h1, 32'h6, rd);
		tick(2);
		chk({ctl.run, ctl.sts_full_irq}, 2'b11);
		@(posedge core_clk_i);
		st.sts_full <= 1'b0;
		$display("run test done");
	endtask : t_run
	task automatic t_flush;
		wb(1, 8'h70, 4'h2, 32'h8000, rd);
		#1 chk({ctl.sts_ptr_clr, ctl.dat_ptr_clr}, 2'b10);
		tick(1);
		chk({ctl.sts_ptr_clr, ctl.dat_ptr_clr}, 2'b00);
		wb(1, 8'h70, 4'h2, 32'h4000, rd);
		#1 chk({ctl.sts_ptr_clr, ctl.dat_ptr_clr}, 2'b01);
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h6);
		$display("flush test done");
	endtask : t_flush
	task automatic t_stop;
		wb(1, 8'h70, 4'h1, 32'h7, rd);
		tick(3);
		chk(ctl.stop_req, 1'b1);
		wb(1, 8'h70, 4'h1, 32'h6, rd);
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h7);
		@(posedge core_clk_i);
		st.halted <= 1'b1;
		tick(3);
		chk({ctl.stop_req, ctl.enable, ctl.run}, 3'b000);
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h4);
		// stop with the transmitter already off clears once halted is seen
		wb(1, 8'h70, 4'h1, 32'h5, rd);
		tick(2);
		chk({ctl.stop_req, ctl.enable}, 2'b00);
		wb(0, 8'h70, 4'hF, 0, rd);
		chk(rd, 32'h4);
		st.halted <= 1'b0;
		$display("stop test done");
	endtask : t_stop
	task automatic end_sim;
		$display("tests %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial begin
		sys_rst_i = 1'b1;
		req = '0;
		st = '0;
		error_cnt = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_rsvd;
		t_alloc;
		t_run;
		t_flush;
		t_stop;
		end_sim;
	end
	// whole run is under two hundred cycles
	initial begin
		repeat (5000) @(posedge core_clk_i);
		error_cnt++;
		end_sim;
	end
endmodule : tb_tfcc_top
